//--- logic/agrv_config.sv
// Gain, rate and voltage-source configuration registers with settle timer
`timescale 1ns/100ps

// How it works
// - Delay field sets first-conversion wait periods
// - Amp enable field: bypass, enable, reserved
// - Gain equals two to the code when enabled, else unity
// - Gain register at 03h, resets 00h
// - Chop bit enables input swap averaging
// - Bit 6 selects internal or external clock
// - Bit 5 selects continuous or single-shot
// - Bit 4 selects sinc3 or low-latency
// - Rate field codes, default 20, F reserved
// - Rate register at 04h, resets 14h
// - Source register at 05h, resets 10h
// - Monitor field enables level monitors
// - Source select: pair0, pair1, internal
// - Internal source off, run-only, always on
// - Bypass bit set disables its buffer
module agrv_config (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     arst_n_i,
  // Register access from the serial command decoder
  input  wire logic                     reg_wr_i,
  input  wire logic                     reg_rd_i,
  input  wire logic [7:0]               reg_addr_i,
  input  wire logic [7:0]               reg_wdata_i,
  output logic      [7:0]               reg_rdata_o,
  // Timing and power state
  input  wire logic                     mod_tick_i,
  input  wire logic                     powerdown_i,
  // Amplifier
  output logic                          amp_enable_o,
  output logic      [7:0]               gain_factor_o,
  output logic                          amp_reserved_o,
  // Conversion control
  output logic                          settle_busy_o,
  output logic                          first_conv_o,
  output logic                          chop_en_o,
  output logic                          ext_clk_sel_o,
  output logic                          single_shot_o,
  output logic                          low_latency_o,
  output logic      [3:0]               output_rate_sel_o,
  output logic                          rate_reserved_o,
  // Voltage source
  output logic                          mon_low_en_o,
  output logic                          mon_third_en_o,
  output logic                          mon_pull_en_o,
  output logic                          pos_buf_en_o,
  output logic                          neg_buf_en_o,
  output logic      [1:0]               source_input_sel_o,
  output logic                          source_reserved_o,
  output logic                          vint_on_o
);
  import agrv_pkg::*;

  function automatic logic [DLY_W-1:0] delay_periods(input logic [2:0] code);
    logic [DLY_W-1:0] r;
    r = DLY_CODE0;
    unique case (code)
      3'h0: r = DLY_CODE0;
      3'h1: r = DLY_CODE1;
      3'h2: r = DLY_CODE2;
      3'h3: r = DLY_CODE3;
      3'h4: r = DLY_CODE4;
      3'h5: r = DLY_CODE5;
      3'h6: r = DLY_CODE6;
      3'h7: r = DLY_CODE7;
    endcase
    return r;
  endfunction

  agrv_gain_reg_t   gain_q, gain_d;
  agrv_rate_reg_t   rate_q, rate_d;
  agrv_vsrc_reg_t   vsrc_q, vsrc_d;
  agrv_settle_st_t  st_q, st_d;
  logic [DLY_W-1:0] cnt_q, cnt_d;
  logic [7:0]       rdata_d;

  wire logic wr_gain  = reg_wr_i && (reg_addr_i == ADDR_AMP_GAIN_DELAY);
  wire logic wr_rate  = reg_wr_i && (reg_addr_i == ADDR_RATE_MODE);
  wire logic wr_vsrc  = reg_wr_i && (reg_addr_i == ADDR_VSOURCE_CTRL);
  // Any of these writes restarts the filter
  wire logic restart  = wr_gain || wr_rate || wr_vsrc;
  wire logic cnt_last = (st_q == ST_WAIT) && mod_tick_i && (cnt_q == DLY_ONE);

  assign gain_d = wr_gain ? agrv_gain_reg_t'(reg_wdata_i) : gain_q;
  assign rate_d = wr_rate ? agrv_rate_reg_t'(reg_wdata_i) : rate_q;
  assign vsrc_d = wr_vsrc ? agrv_vsrc_reg_t'(reg_wdata_i) : vsrc_q;

  assign rdata_d = (reg_addr_i == ADDR_AMP_GAIN_DELAY) ? gain_q :
                   (reg_addr_i == ADDR_RATE_MODE)      ? rate_q :
                   (reg_addr_i == ADDR_VSOURCE_CTRL)   ? vsrc_q : RDATA_UNMAPPED;

  // settle countdown
  // New delay code takes effect for the write that carries it
  assign cnt_d = restart  ? delay_periods(gain_d.delay) :
                 (st_q == ST_WAIT && mod_tick_i) ? cnt_q - DLY_ONE : cnt_q;
  assign st_d  = restart ? ST_WAIT : (cnt_last ? ST_IDLE : st_q);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gain_q <= agrv_gain_reg_t'(RST_AMP_GAIN_DELAY);
      rate_q <= agrv_rate_reg_t'(RST_RATE_MODE);
      vsrc_q <= agrv_vsrc_reg_t'(RST_VSOURCE_CTRL);
      st_q   <= ST_IDLE;
      cnt_q  <= '0;
    end else begin
      gain_q <= gain_d;
      rate_q <= rate_d;
      vsrc_q <= vsrc_d;
      st_q   <= st_d;
      cnt_q  <= cnt_d;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o   <= RDATA_UNMAPPED;
      settle_busy_o <= 1'b0;
      first_conv_o  <= 1'b0;
    end else begin
      if (reg_rd_i) begin
        reg_rdata_o <= rdata_d;
      end
      settle_busy_o <= (st_d == ST_WAIT);
      first_conv_o  <= cnt_last && !restart;
    end
  end

  // Decoded controls lag the register by one cycle so every output is a flop
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      amp_enable_o       <= 1'b0;
      gain_factor_o      <= GAIN_UNITY;
      amp_reserved_o     <= 1'b0;
      chop_en_o          <= 1'b0;
      ext_clk_sel_o      <= 1'b0;
      single_shot_o      <= 1'b0;
      low_latency_o      <= 1'b1;
      output_rate_sel_o  <= RST_RATE_MODE[3:0];
      rate_reserved_o    <= 1'b0;
      mon_low_en_o       <= 1'b0;
      mon_third_en_o     <= 1'b0;
      mon_pull_en_o      <= 1'b0;
      pos_buf_en_o       <= 1'b1;
      neg_buf_en_o       <= 1'b0;
      source_input_sel_o <= SRC_EXT0;
      source_reserved_o  <= 1'b0;
      vint_on_o          <= 1'b0;
    end else begin
      amp_enable_o   <= (gain_q.amp_enable_sel == AMP_ON);
      amp_reserved_o <= gain_q.amp_enable_sel[1];
      // bypass forces unity in case the host skips it
      gain_factor_o  <= (gain_q.amp_enable_sel == AMP_ON) ? (GAIN_UNITY << gain_q.gain) : GAIN_UNITY;
      chop_en_o      <= rate_q.chop;
      ext_clk_sel_o  <= rate_q.ext_clk;
      single_shot_o  <= rate_q.single_shot;
      low_latency_o  <= rate_q.low_latency;
      output_rate_sel_o <= rate_q.output_rate_sel;
      rate_reserved_o   <= (rate_q.output_rate_sel == RATE_RESERVED);
      mon_low_en_o   <= (vsrc_q.vsense_monitor_cfg != MON_OFF);
      mon_third_en_o <= (vsrc_q.vsense_monitor_cfg == MON_THIRD);
      mon_pull_en_o  <= (vsrc_q.vsense_monitor_cfg == MON_PULL);
      pos_buf_en_o   <= !vsrc_q.pos_buffer_bypass;
      neg_buf_en_o   <= !vsrc_q.neg_buffer_bypass;
      source_input_sel_o <= vsrc_q.source_input_sel;
      source_reserved_o  <= (vsrc_q.source_input_sel > SRC_INTERNAL);
      vint_on_o <= (vsrc_q.internal_vsource_cfg == VINT_ALWAYS) ||
                   ((vsrc_q.internal_vsource_cfg == VINT_ON_RUN) && !powerdown_i);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_gain_write;
    wr_gain |=> (gain_q == $past(reg_wdata_i));
  endproperty
  a_gain_write: assert property (p_gain_write) else $error("gain register write lost");

  property p_rate_hold;
    !wr_rate |=> $stable(rate_q);
  endproperty
  a_rate_hold: assert property (p_rate_hold) else $error("rate register changed without write");

  property p_delay_load;
    wr_gain |=> (cnt_q == delay_periods($past(reg_wdata_i[7:5]))) && settle_busy_o;
  endproperty
  a_delay_load: assert property (p_delay_load) else $error("settle count not loaded");

  property p_settle_end;
    (st_q == ST_WAIT && mod_tick_i && cnt_q == DLY_ONE && !restart) |=> first_conv_o && !settle_busy_o;
  endproperty
  a_settle_end: assert property (p_settle_end) else $error("first conversion not flagged");

  property p_gain_out;
    (gain_q.amp_enable_sel == AMP_ON && !wr_gain) |=> ##1 (gain_factor_o == (GAIN_UNITY << $past(gain_q.gain, 2)));
  endproperty
  a_gain_out: assert property (p_gain_out) else $error("gain factor wrong");

  property p_amp_en;
    ##1 (amp_enable_o == ($past(gain_q.amp_enable_sel) == AMP_ON));
  endproperty
  a_amp_en: assert property (p_amp_en) else $error("amplifier enable wrong");

  property p_modes;
    ##1 ({chop_en_o, ext_clk_sel_o, single_shot_o, low_latency_o} == $past(rate_q[7:4]));
  endproperty
  a_modes: assert property (p_modes) else $error("mode outputs wrong");

  property p_bufs;
    ##1 (pos_buf_en_o != $past(vsrc_q.pos_buffer_bypass)) && (neg_buf_en_o != $past(vsrc_q.neg_buffer_bypass));
  endproperty
  a_bufs: assert property (p_bufs) else $error("buffer enables wrong");

  property p_vint;
    (vsrc_q.internal_vsource_cfg == VINT_ON_RUN && powerdown_i) |=> !vint_on_o;
  endproperty
  a_vint: assert property (p_vint) else $error("internal source on in power-down");

  c_gain_write:   cover property (wr_gain ##1 settle_busy_o);
  c_first_conv:   cover property (first_conv_o);
  c_single_shot:  cover property (wr_rate ##2 single_shot_o);
endmodule

//--- logic/agrv_pkg.sv
// Package for the converter gain, rate and voltage-source configuration block
package agrv_pkg;

  // Register map, documented offsets
  localparam logic [7:0] ADDR_AMP_GAIN_DELAY = 8'h03;
  localparam logic [7:0] ADDR_RATE_MODE      = 8'h04;
  localparam logic [7:0] ADDR_VSOURCE_CTRL   = 8'h05;

  // Reset values
  localparam logic [7:0] RST_AMP_GAIN_DELAY = 8'h00;
  localparam logic [7:0] RST_RATE_MODE      = 8'h14;
  localparam logic [7:0] RST_VSOURCE_CTRL   = 8'h10;
  localparam logic [7:0] RDATA_UNMAPPED     = 8'h00;

  // Field codes
  localparam logic [1:0] AMP_BYPASS      = 2'h0;
  localparam logic [1:0] AMP_ON          = 2'h1;
  localparam logic [3:0] RATE_LAST_VALID = 4'h9;
  localparam logic [3:0] RATE_RESERVED   = 4'hF;
  localparam logic [1:0] MON_OFF         = 2'h0;
  localparam logic [1:0] MON_THIRD       = 2'h2;
  localparam logic [1:0] MON_PULL        = 2'h3;
  localparam logic [1:0] SRC_EXT0        = 2'h0;
  localparam logic [1:0] SRC_EXT1        = 2'h1;
  localparam logic [1:0] SRC_INTERNAL    = 2'h2;
  localparam logic [1:0] VINT_ON_RUN     = 2'h1;
  localparam logic [1:0] VINT_ALWAYS     = 2'h2;
  localparam logic [7:0] GAIN_UNITY      = 8'h01;

  // Settling delays in modulator periods
  localparam int          DLY_W     = 13;
  localparam logic [12:0] DLY_CODE0 = 13'h000E;
  localparam logic [12:0] DLY_CODE1 = 13'h0019;
  localparam logic [12:0] DLY_CODE2 = 13'h0040;
  localparam logic [12:0] DLY_CODE3 = 13'h0100;
  localparam logic [12:0] DLY_CODE4 = 13'h0400;
  localparam logic [12:0] DLY_CODE5 = 13'h0800;
  localparam logic [12:0] DLY_CODE6 = 13'h1000;
  localparam logic [12:0] DLY_CODE7 = 13'h0001;
  localparam logic [12:0] DLY_ONE   = 13'h0001;

  typedef struct packed {
    logic [2:0] delay;
    logic [1:0] amp_enable_sel;
    logic [2:0] gain;
  } agrv_gain_reg_t;

  typedef struct packed {
    logic       chop;
    logic       ext_clk;
    logic       single_shot;
    logic       low_latency;
    logic [3:0] output_rate_sel;
  } agrv_rate_reg_t;

  typedef struct packed {
    logic [1:0] vsense_monitor_cfg;
    logic       pos_buffer_bypass;
    logic       neg_buffer_bypass;
    logic [1:0] source_input_sel;
    logic [1:0] internal_vsource_cfg;
  } agrv_vsrc_reg_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } agrv_settle_st_t;

endpackage

//--- testbench/agrv_host.sv
// Host model that writes and reads the configuration registers
`timescale 1ns/100ps
module agrv_host (
  // Clock
  input  wire logic       clk_i,
  // Register access
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i
);
  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
  end
  // Released lines flip, so a stale value never passes for a live one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_o    <= 1'b1;
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    @(posedge clk_i);
    reg_wr_o    <= 1'b0;
    reg_addr_o  <= ~a;
    reg_wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_rd_o   <= 1'b1;
    reg_addr_o <= a;
    @(posedge clk_i);
    reg_rd_o   <= 1'b0;
    reg_addr_o <= ~a;
    @(posedge clk_i);
    #1;
    d = reg_rdata_i;
  endtask
endmodule

//--- testbench/test_adc_gain_rate_vref_config.sv
// Self-checking bench for the gain, rate and voltage-source configuration
`timescale 1ns/100ps
module test_adc_gain_rate_vref_config;
  import agrv_pkg::*;
  logic       clk_i = 1'b0, arst_n_i = 1'b0, mod_tick_i = 1'b0, powerdown_i = 1'b0;
  logic       reg_wr, reg_rd, amp_en, amp_res, busy, first, chop, ext_clk, single, low_lat, rate_res;
  logic       mon_low, mon_third, mon_pull, pos_buf, neg_buf, src_res, vint;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val, gain_f;
  logic [3:0] rate_sel;
  logic [1:0] src_sel;
  int         n_errors = 0, n_checks = 0, n_conv = 0, cyc = 0;
  int         dly [8] = '{14, 25, 64, 256, 1024, 2048, 4096, 1};

  agrv_host host (.clk_i(clk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata));
  agrv_config dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .mod_tick_i(mod_tick_i),
    .powerdown_i(powerdown_i), .amp_enable_o(amp_en), .gain_factor_o(gain_f), .amp_reserved_o(amp_res),
    .settle_busy_o(busy), .first_conv_o(first), .chop_en_o(chop), .ext_clk_sel_o(ext_clk),
    .single_shot_o(single), .low_latency_o(low_lat), .output_rate_sel_o(rate_sel),
    .rate_reserved_o(rate_res), .mon_low_en_o(mon_low), .mon_third_en_o(mon_third),
    .mon_pull_en_o(mon_pull), .pos_buf_en_o(pos_buf), .neg_buf_en_o(neg_buf),
    .source_input_sel_o(src_sel), .source_reserved_o(src_res), .vint_on_o(vint));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // Ceiling well above the longest settle sweep
  always @(posedge clk_i) begin
    cyc++;
    if (first === 1'b1) n_conv++;
    if (cyc == 60000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Write, then read back; the read also lets decoded outputs settle
  task automatic wrc(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    host.rd(a, rd_val);
    chk(rd_val, d);
  endtask
  task automatic tick();
    @(posedge clk_i);
    mod_tick_i <= 1'b1;
    @(posedge clk_i);
    mod_tick_i <= 1'b0;
  endtask
  function automatic logic [7:0] vsrc_vec();
    return {mon_low, mon_third, mon_pull, pos_buf, neg_buf, src_res, vint, 1'b0};
  endfunction

  task automatic t_reset();
    host.wr(8'h07, 8'hFF);
    host.rd(8'h03, rd_val);
    chk(rd_val, 8'h00);
    host.rd(8'h04, rd_val);
    chk(rd_val, 8'h14);
    host.rd(8'h05, rd_val);
    chk(rd_val, 8'h10);
    host.rd(8'h07, rd_val);
    chk(rd_val, 8'h00);
    chk({chop, ext_clk, single, low_lat, rate_sel}, 8'h14);
    chk(vsrc_vec(), 8'h10);
    chk(gain_f, 8'h01);
  endtask
  task automatic t_gain();
    for (int g = 0; g < 8; g++) begin
      wrc(8'h03, 8'h08 | 8'(g));
      chk(gain_f, 8'h01 << g);
      chk({6'h00, amp_res, amp_en}, 8'h01);
    end
    // Gain code 000 with every enable code, as the host must when bypassing
    for (int c = 3; c >= 0; c--) begin
      wrc(8'h03, 8'(c) << 3);
      chk({6'h00, amp_res, amp_en}, {6'h00, c[1], c == 1});
      chk(gain_f, 8'h01);
    end
  endtask
  task automatic t_rate();
    for (int c = 0; c < 16; c++) begin
      wrc(8'h04, 8'(c * 17));
      chk({chop, ext_clk, single, low_lat, rate_sel}, 8'(c * 17));
      chk({7'h00, rate_res}, {7'h00, c == 15});
    end
  endtask
  task automatic t_vsrc();
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 4; i++) begin
        @(posedge clk_i);
        powerdown_i <= p[0];
        wrc(8'h05, {i[1:0], i[0], i[1], i[1:0], i[1:0]});
        chk(vsrc_vec(), {i != 0, i == 2, i == 3, !i[0], !i[1], i == 3,
          i == 2 || (i == 1 && p == 0), 1'b0});
        chk({6'h00, src_sel}, 8'(i));
      end
    end
  endtask
  task automatic t_settle();
    int k;
    for (int c = 0; c < 8; c++) begin
      host.wr(8'h03, {3'(c), 5'h00});
      k = n_conv;
      repeat (dly[c] - 1) tick();
      @(posedge clk_i);
      #1;
      chk({busy, 7'(n_conv - k)}, 8'h80);
      tick();
      repeat (2) @(posedge clk_i);
      #1;
      chk({busy, 7'(n_conv - k)}, 8'h01);
    end
  endtask

  // Restart on the last tick swallows the pulse; unmapped writes leave the timer alone
  task automatic t_restart();
    int k;
    host.wr(8'h03, 8'hE0);
    k = n_conv;
    fork
      host.wr(8'h04, 8'h14);
      tick();
    join
    @(posedge clk_i);
    #1;
    chk({busy, 7'(n_conv - k)}, 8'h80);
    tick();
    repeat (2) @(posedge clk_i);
    #1;
    chk({busy, 7'(n_conv - k)}, 8'h01);
    host.wr(8'h07, 8'h00);
    @(posedge clk_i);
    #1;
    chk({busy, 7'(n_conv - k)}, 8'h01);
  endtask
  // A reset in mid-run must restore every reset value, timer included
  task automatic t_rerun();
    host.wr(8'h03, 8'hFF);
    host.wr(8'h04, 8'hEB);
    host.wr(8'h05, 8'hEF);
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    host.rd(8'h03, rd_val);
    chk(rd_val, 8'h00);
    host.rd(8'h04, rd_val);
    chk(rd_val, 8'h14);
    host.rd(8'h05, rd_val);
    chk(rd_val, 8'h10);
    chk({chop, ext_clk, single, low_lat, rate_sel}, 8'h14);
    chk(vsrc_vec(), 8'h10);
    chk(gain_f, 8'h01);
    chk({7'h00, busy}, 8'h00);
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_reset();
    t_gain();
    t_rate();
    t_vsrc();
    t_settle();
    t_restart();
    t_rerun();
    close_out();
  end
endmodule
